/* shared/store_params_pkg.sv */
// Constants, types and state records of the store-parameters handler
package store_params_pkg;

  // Object addressing
  localparam logic [15:0] STORE_INDEX = 16'h1010;
  localparam logic [7:0] SUB_ENTRY_COUNT = 8'h00;
  localparam logic [7:0] SUB_SAVE_ALL = 8'h01;

  // Register contents
  localparam logic [31:0] SAVE_MAGIC = 32'h65766173;
  localparam logic [31:0] SAVE_ALL_RESET = 32'h00000001;
  localparam logic [31:0] SAVE_ALL_DONE = 32'h00000001;
  localparam logic [31:0] ENTRY_COUNT_VAL = 32'h00000001;

  // Abort codes returned on refused requests
  localparam logic [31:0] ABORT_READ_ONLY = 32'h06010002;
  localparam logic [31:0] ABORT_NO_OBJECT = 32'h06020000;
  localparam logic [31:0] ABORT_NO_SUB = 32'h06090011;
  localparam logic [31:0] ABORT_BAD_VALUE = 32'h06090030;
  localparam logic [31:0] ABORT_NOT_STORED = 32'h08000020;

  // Timing
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned BACKUP_MAX_S = 10;
  localparam int unsigned BACKUP_MAX_CYC = BACKUP_MAX_S * CLK_HZ;

  // Object table
  localparam int unsigned OBJ_IDX_W = 16;
  localparam int unsigned NUM_OBJ_DEFAULT = 256;

  typedef struct packed {
    logic write;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] data;
  } sdo_req_s;

  typedef struct packed {
    logic abort;
    logic [31:0] code;
    logic [31:0] data;
  } sdo_rsp_s;

  typedef enum logic [1:0] {W_IDLE, W_READ, W_CHECK, W_WRITE} walk_state_e;

  typedef struct packed {
    walk_state_e state;
    logic [OBJ_IDX_W-1:0] idx;
    logic ee_wr;
    logic [31:0] ee_data;
    logic done;
    logic ok;
    logic cr_seen;
  } walk_state_s;

  typedef struct packed {
    logic busy;
    logic ready;
    logic [31:0] save_val;
    logic rsp_valid;
    sdo_rsp_s rsp;
    logic start;
    logic restart_pending;
    logic [31:0] timer;
  } ctl_state_s;

endpackage : store_params_pkg

/* rtl/nvm_backup_walker.sv */
// Walks the object table and copies flagged objects into EEPROM
`timescale 1ns/1ps
module nvm_backup_walker
  import store_params_pkg::*;
#(
  parameter int unsigned NUM_OBJ = NUM_OBJ_DEFAULT
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic uv_alarm_i,
  output logic done_o,
  output logic ok_o,
  output logic cr_o,
  // Object RAM, one-cycle read
  output logic [OBJ_IDX_W-1:0] obj_addr_o,
  input wire logic obj_nv_i,
  input wire logic obj_cr_i,
  input wire logic [31:0] obj_data_i,
  // EEPROM write port
  output logic ee_wr_o,
  output logic [OBJ_IDX_W-1:0] ee_addr_o,
  output logic [31:0] ee_data_o,
  input wire logic ee_done_i
);

  localparam logic [OBJ_IDX_W-1:0] LAST_IDX = OBJ_IDX_W'(NUM_OBJ - 1);

  walk_state_s st;
  walk_state_s next_st;

  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    case (st.state)
      W_IDLE:
      begin
        if (start_i)
        begin
          next_st.idx = '0;
          next_st.cr_seen = 1'b0;
          next_st.state = W_READ;
        end
      end
      W_READ:
      begin
        next_st.state = W_CHECK;
      end
      W_CHECK:
      begin
        if (uv_alarm_i)
        begin
          // EEPROM unreachable, finish as failed
          next_st.state = W_IDLE;
          next_st.done = 1'b1;
          next_st.ok = 1'b0;
        end
        else if (obj_nv_i)
        begin
          next_st.ee_wr = 1'b1;
          next_st.ee_data = obj_data_i;
          next_st.cr_seen = st.cr_seen | obj_cr_i;
          next_st.state = W_WRITE;
        end
        else if (st.idx == LAST_IDX)
        begin
          next_st.state = W_IDLE;
          next_st.done = 1'b1;
          next_st.ok = 1'b1;
        end
        else
        begin
          next_st.idx = st.idx + 1'b1;
          next_st.state = W_READ;
        end
      end
      W_WRITE:
      begin
        if (uv_alarm_i)
        begin
          // Write strobe withdrawn at once; the word is lost
          next_st.ee_wr = 1'b0;
          next_st.state = W_IDLE;
          next_st.done = 1'b1;
          next_st.ok = 1'b0;
        end
        else if (ee_done_i)
        begin
          next_st.ee_wr = 1'b0;
          if (st.idx == LAST_IDX)
          begin
            next_st.state = W_IDLE;
            next_st.done = 1'b1;
            next_st.ok = 1'b1;
          end
          else
          begin
            next_st.idx = st.idx + 1'b1;
            next_st.state = W_READ;
          end
        end
      end
      default:
      begin
        next_st.state = W_IDLE;
      end
    endcase
    if (abort_i)
    begin
      next_st.state = W_IDLE;
      next_st.ee_wr = 1'b0;
      next_st.done = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      st <= '{state: W_IDLE, idx: '0, ee_wr: 1'b0, ee_data: '0, done: 1'b0, ok: 1'b0,
              cr_seen: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign done_o = st.done;
  assign ok_o = st.ok;
  assign cr_o = st.cr_seen;
  assign obj_addr_o = st.idx;
  assign ee_wr_o = st.ee_wr;
  assign ee_addr_o = st.idx;
  assign ee_data_o = st.ee_data;

  AST_NV_ONLY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(ee_wr_o) |-> $past(obj_nv_i) && $past(st.state == W_CHECK))
    else $error("EEPROM write started for an object not flagged non-volatile");

  AST_UV_NOWRITE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    uv_alarm_i |=> !ee_wr_o)
    else $error("EEPROM write strobe held during undervoltage alarm");

endmodule : nvm_backup_walker

/* rtl/store_params_nvm_handler.sv */
// Store-parameters object handler: save-all trigger, abort answers, backup control
//
// What this block does
// - Magic value on save-all starts EEPROM backup
// - Only non-volatile flagged objects are written
// - Save-all reads one after backup ends
// - Save-all reads one after power-on
// - Entry-count subindex is read-only, returns one
// - Write to entry-count subindex is aborted
// - Non-magic save-all write aborted, no backup
// - No mailbox command accepted during backup
// - Backup bounded by ten seconds
// - No EEPROM storing under control-power undervoltage
// - Saved restart-type objects need power cycle
`timescale 1ns/1ps
module store_params_nvm_handler
  import store_params_pkg::*;
#(
  parameter int unsigned NUM_OBJ = NUM_OBJ_DEFAULT,
  parameter int unsigned TIMEOUT_CYC = BACKUP_MAX_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Mailbox request
  input wire logic req_valid_i,
  input wire sdo_req_s req_i,
  output logic req_ready_o,
  // Mailbox answer
  output logic rsp_valid_o,
  output sdo_rsp_s rsp_o,
  // Drive status
  input wire logic uv_alarm_i,
  output logic busy_o,
  output logic restart_pending_o,
  // Object RAM
  output logic [OBJ_IDX_W-1:0] obj_addr_o,
  input wire logic obj_nv_i,
  input wire logic obj_cr_i,
  input wire logic [31:0] obj_data_i,
  // EEPROM write port
  output logic ee_wr_o,
  output logic [OBJ_IDX_W-1:0] ee_addr_o,
  output logic [31:0] ee_data_o,
  input wire logic ee_done_i
);

  localparam logic [31:0] TIMER_LAST = 32'(TIMEOUT_CYC - 1);

  ctl_state_s st;
  ctl_state_s next_st;

  logic accept;
  logic is_store_obj;
  logic magic_hit;
  logic timed_out;
  logic bk_done;
  logic bk_ok;
  logic bk_cr;

  // Ready is registered low while busy, so nothing slips in
  assign accept = req_valid_i && st.ready;
  assign is_store_obj = req_i.index == STORE_INDEX;
  assign magic_hit = req_i.data == SAVE_MAGIC;
  assign timed_out = st.busy && (st.timer == TIMER_LAST);

  nvm_backup_walker #(
    .NUM_OBJ(NUM_OBJ)
  ) u_walker (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(st.start),
    .abort_i(timed_out),
    .uv_alarm_i(uv_alarm_i),
    .done_o(bk_done),
    .ok_o(bk_ok),
    .cr_o(bk_cr),
    .obj_addr_o(obj_addr_o),
    .obj_nv_i(obj_nv_i),
    .obj_cr_i(obj_cr_i),
    .obj_data_i(obj_data_i),
    .ee_wr_o(ee_wr_o),
    .ee_addr_o(ee_addr_o),
    .ee_data_o(ee_data_o),
    .ee_done_i(ee_done_i)
  );

  always_comb
  begin
    next_st = st;
    next_st.rsp_valid = 1'b0;
    next_st.start = 1'b0;
    if (accept)
    begin
      next_st.rsp_valid = 1'b1;
      next_st.rsp = '{abort: 1'b0, code: '0, data: '0};
      if (!is_store_obj)
      begin
        next_st.rsp.abort = 1'b1;
        next_st.rsp.code = ABORT_NO_OBJECT;
      end
      else if (req_i.sub == SUB_ENTRY_COUNT)
      begin
        if (req_i.write)
        begin
          next_st.rsp.abort = 1'b1;
          next_st.rsp.code = ABORT_READ_ONLY;
        end
        else
        begin
          next_st.rsp.data = ENTRY_COUNT_VAL;
        end
      end
      else if (req_i.sub == SUB_SAVE_ALL)
      begin
        if (!req_i.write)
        begin
          next_st.rsp.data = st.save_val;
        end
        else if (!magic_hit)
        begin
          next_st.rsp.abort = 1'b1;
          next_st.rsp.code = ABORT_BAD_VALUE;
        end
        else if (uv_alarm_i)
        begin
          // Refused up front: EEPROM is out of reach
          next_st.rsp.abort = 1'b1;
          next_st.rsp.code = ABORT_NOT_STORED;
          next_st.save_val = SAVE_ALL_DONE;
        end
        else
        begin
          // Answer is held back until the backup ends
          next_st.rsp_valid = 1'b0;
          next_st.busy = 1'b1;
          next_st.ready = 1'b0;
          next_st.start = 1'b1;
          next_st.save_val = req_i.data;
          next_st.timer = '0;
        end
      end
      else
      begin
        next_st.rsp.abort = 1'b1;
        next_st.rsp.code = ABORT_NO_SUB;
      end
    end
    if (st.busy)
    begin
      next_st.timer = st.timer + 32'h1;
      if (timed_out || bk_done)
      begin
        // Completion is only honoured while the busy flag stands
        next_st.busy = 1'b0;
        next_st.ready = 1'b1;
        next_st.save_val = SAVE_ALL_DONE;
        next_st.rsp_valid = 1'b1;
        next_st.rsp.data = '0;
        next_st.rsp.abort = timed_out || !bk_ok;
        next_st.rsp.code = (timed_out || !bk_ok) ? ABORT_NOT_STORED : 32'h0;
        // Restart-type objects only act after the next power-up
        if (!timed_out && bk_cr)
        begin
          next_st.restart_pending = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      st <= '{busy: 1'b0, ready: 1'b1, save_val: SAVE_ALL_RESET,
              rsp_valid: 1'b0, rsp: '{abort: 1'b0, code: '0, data: '0},
              start: 1'b0, restart_pending: 1'b0, timer: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign req_ready_o = st.ready;
  assign rsp_valid_o = st.rsp_valid;
  assign rsp_o = st.rsp;
  assign busy_o = st.busy;
  assign restart_pending_o = st.restart_pending;

  sequence seq_magic_acc;
    accept && is_store_obj && req_i.sub == SUB_SAVE_ALL && req_i.write && magic_hit
      && !uv_alarm_i;
  endsequence

  sequence seq_backup_running;
    st.busy && !req_ready_o && !rsp_valid_o;
  endsequence

  AST_MAGIC_START: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    seq_magic_acc |=> st.start ##1 u_walker.st.state == W_READ)
    else $error("Magic write did not launch the backup walker");

  AST_BUSY_SPAN: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    seq_magic_acc |=> seq_backup_running [*2])
    else $error("Busy flag not held after backup start");

  AST_DONE_ONE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $fell(st.busy) |-> st.save_val == SAVE_ALL_DONE && rsp_valid_o)
    else $error("Save-all not set to one at backup end");

  AST_RESET_SAVE: assert property (@(posedge sys_clk_i)
    $fell(sys_rst_i) |-> st.save_val == SAVE_ALL_RESET && !st.busy)
    else $error("Save-all not one after reset");

  AST_COUNT_READ: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    accept && is_store_obj && req_i.sub == SUB_ENTRY_COUNT && !req_i.write
      |=> rsp_valid_o && !rsp_o.abort && rsp_o.data == ENTRY_COUNT_VAL)
    else $error("Entry count read did not return one");

  AST_SUB0_WRITE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    accept && is_store_obj && req_i.sub == SUB_ENTRY_COUNT && req_i.write
      |=> rsp_valid_o && rsp_o.abort && rsp_o.code == ABORT_READ_ONLY)
    else $error("Entry count write was not aborted");

  AST_BAD_VALUE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    accept && is_store_obj && req_i.sub == SUB_SAVE_ALL && req_i.write && !magic_hit
      |=> rsp_valid_o && rsp_o.abort && rsp_o.code == ABORT_BAD_VALUE && !st.busy && !st.start)
    else $error("Non-magic save-all write not aborted or started a backup");

  AST_BUSY_READY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    st.busy |-> !req_ready_o)
    else $error("Mailbox ready while backup busy");

  AST_TIMEOUT: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    timed_out |=> !st.busy && rsp_o.abort && rsp_o.code == ABORT_NOT_STORED)
    else $error("Backup not ended at the time limit");

  AST_UV_REFUSE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    accept && is_store_obj && req_i.sub == SUB_SAVE_ALL && req_i.write && magic_hit
      && uv_alarm_i |=> !st.busy && rsp_o.abort ##1 !ee_wr_o)
    else $error("Backup started under undervoltage alarm");

  AST_RESTART: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(restart_pending_o) |-> $past(bk_done) && $past(bk_cr) && $past(st.busy))
    else $error("Restart flag raised without a completed restart-type save");

endmodule : store_params_nvm_handler

/* tb/nvm_store_model.sv */
// Object RAM and EEPROM model on the backup side of the handler
`timescale 1ns/1ps
module nvm_store_model
  import store_params_pkg::*;
(
  // Clock
  input wire logic sys_clk_i,
  // Object RAM
  input wire logic [OBJ_IDX_W-1:0] obj_addr_i,
  output logic obj_nv_o = 1'b0,
  output logic obj_cr_o = 1'b0,
  output logic [31:0] obj_data_o = 32'h0,
  // EEPROM
  input wire logic ee_wr_i,
  input wire logic [OBJ_IDX_W-1:0] ee_addr_i,
  input wire logic [31:0] ee_data_i,
  output logic ee_done_o = 1'b0,
  input wire logic [31:0] lat_i
);
  logic [31:0] ee_mem [4] = '{default: 32'h0};
  int wr_cnt = 0;
  int wait_cnt = 0;
  logic acked = 1'b0;

  // Even objects non-volatile, object 2 restart-type
  always @(posedge sys_clk_i)
  begin
    obj_nv_o <= ~obj_addr_i[0];
    obj_cr_o <= (obj_addr_i == 16'h0002);
    obj_data_o <= {16'ha5a5, obj_addr_i};
    ee_done_o <= 1'b0;
    wait_cnt <= ee_wr_i ? wait_cnt + 1 : 0;
    // One done per request; a held write is not acked twice
    if (ee_wr_i && !acked && wait_cnt >= lat_i)
    begin
      ee_done_o <= 1'b1;
      acked <= 1'b1;
      ee_mem[ee_addr_i[1:0]] <= ee_data_i;
      wr_cnt <= wr_cnt + 1;
    end
    if (!ee_wr_i)
      acked <= 1'b0;
  end
endmodule : nvm_store_model

/* tb/testbench.sv */
// Self-checking bench for the store-parameters handler
`timescale 1ns/1ps
module testbench;
  import store_params_pkg::*;
  localparam int unsigned TMO = 200;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  sdo_req_s req_i = '0;
  logic req_ready_o;
  logic rsp_valid_o;
  sdo_rsp_s rsp_o;
  logic uv_alarm_i = 1'b0;
  logic busy_o;
  logic restart_pending_o;
  logic [OBJ_IDX_W-1:0] obj_addr_o;
  logic obj_nv_i;
  logic obj_cr_i;
  logic [31:0] obj_data_i;
  logic ee_wr_o;
  logic [OBJ_IDX_W-1:0] ee_addr_o;
  logic [31:0] ee_data_o;
  logic ee_done_i;
  int lat = 2;
  int n_fail = 0;
  int checks_done = 0;
  int cyc;
  logic busy_seen;
  logic [32:0] ans;

  always #12.5 sys_clk_i = ~sys_clk_i;

  store_params_nvm_handler #(.NUM_OBJ(4), .TIMEOUT_CYC(TMO)) uut (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
    .uv_alarm_i(uv_alarm_i), .busy_o(busy_o), .restart_pending_o(restart_pending_o),
    .obj_addr_o(obj_addr_o), .obj_nv_i(obj_nv_i), .obj_cr_i(obj_cr_i),
    .obj_data_i(obj_data_i), .ee_wr_o(ee_wr_o), .ee_addr_o(ee_addr_o),
    .ee_data_o(ee_data_o), .ee_done_i(ee_done_i));

  nvm_store_model mdl (
    .sys_clk_i(sys_clk_i), .obj_addr_i(obj_addr_o), .obj_nv_o(obj_nv_i),
    .obj_cr_o(obj_cr_i), .obj_data_o(obj_data_i), .ee_wr_i(ee_wr_o),
    .ee_addr_i(ee_addr_o), .ee_data_i(ee_data_o), .ee_done_o(ee_done_i), .lat_i(lat));

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Waits for ready at a falling edge, so it holds through the taking edge
  task automatic send(input logic wr, input logic [7:0] sub, input logic [31:0] d,
    input logic [15:0] idx = STORE_INDEX);
    int n;
    n = 0;
    @(negedge sys_clk_i);
    while (req_ready_o !== 1'b1 && n < 1000)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    chk(req_ready_o, 1'b1);
    req_valid_i = 1'b1;
    req_i = '{write: wr, index: idx, sub: sub, data: d};
    @(negedge sys_clk_i);
    req_valid_i = 1'b0;
  endtask : send

  task automatic wait_rsp();
    cyc = 0;
    busy_seen = 1'b0;
    while (rsp_valid_o !== 1'b1 && cyc < 2000)
    begin
      if (busy_o === 1'b1 && req_ready_o === 1'b0)
        busy_seen = 1'b1;
      @(negedge sys_clk_i);
      cyc++;
    end
    chk(rsp_valid_o, 1'b1);
    ans = {rsp_o.abort, rsp_o.abort ? rsp_o.code : rsp_o.data};
  endtask : wait_rsp

  task automatic xfer(input logic wr, input logic [7:0] sub, input logic [31:0] d,
    input logic [15:0] idx = STORE_INDEX);
    send(wr, sub, d, idx);
    wait_rsp();
  endtask : xfer

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  // Whole run needs a few hundred cycles
  initial
  begin
    #(25 * 20000);
    n_fail++;
    complete_run();
  end

  initial
  begin
    repeat (16) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    xfer(1'b0, SUB_ENTRY_COUNT, 32'h0);
    chk(ans, {1'b0, ENTRY_COUNT_VAL});
    xfer(1'b0, SUB_SAVE_ALL, 32'h0);
    chk(ans, {1'b0, SAVE_ALL_RESET});
    $display("power-on values done");
    xfer(1'b1, SUB_ENTRY_COUNT, 32'h1);
    chk(ans, {1'b1, ABORT_READ_ONLY});
    xfer(1'b1, SUB_SAVE_ALL, 32'h65766174);
    chk(ans, {1'b1, ABORT_BAD_VALUE});
    xfer(1'b0, 8'h02, 32'h0);
    chk(ans, {1'b1, ABORT_NO_SUB});
    xfer(1'b0, SUB_SAVE_ALL, 32'h0, 16'h1011);
    chk(ans, {1'b1, ABORT_NO_OBJECT});
    chk(mdl.wr_cnt, 0);
    chk(restart_pending_o, 1'b0);
    $display("refused requests done");
    // Master starts the backup with the magic word
    xfer(1'b1, SUB_SAVE_ALL, SAVE_MAGIC);
    chk(ans[32], 1'b0);
    chk(busy_seen, 1'b1);
    chk(mdl.wr_cnt, 2);
    chk(mdl.ee_mem[0], 32'ha5a50000);
    chk(mdl.ee_mem[1], 32'h0);
    chk(mdl.ee_mem[2], 32'ha5a50002);
    chk(mdl.ee_mem[3], 32'h0);
    chk(restart_pending_o, 1'b1);
    xfer(1'b0, SUB_SAVE_ALL, 32'h0);
    chk(ans, {1'b0, SAVE_ALL_DONE});
    $display("backup done");
    uv_alarm_i = 1'b1;
    xfer(1'b1, SUB_SAVE_ALL, SAVE_MAGIC);
    chk(ans, {1'b1, ABORT_NOT_STORED});
    uv_alarm_i = 1'b0;
    lat = 20;
    send(1'b1, SUB_SAVE_ALL, SAVE_MAGIC);
    repeat (4) @(negedge sys_clk_i);
    uv_alarm_i = 1'b1;
    wait_rsp();
    uv_alarm_i = 1'b0;
    chk(ans, {1'b1, ABORT_NOT_STORED});
    chk(mdl.wr_cnt, 2);
    xfer(1'b0, SUB_SAVE_ALL, 32'h0);
    chk(ans, {1'b0, SAVE_ALL_DONE});
    $display("undervoltage done");
    // EEPROM slower than the shortened time limit
    lat = 1000;
    xfer(1'b1, SUB_SAVE_ALL, SAVE_MAGIC);
    chk(ans, {1'b1, ABORT_NOT_STORED});
    chk(cyc >= TMO - 8 && cyc <= TMO + 8, 1'b1);
    xfer(1'b0, SUB_SAVE_ALL, 32'h0);
    chk(ans, {1'b0, SAVE_ALL_DONE});
    $display("time limit done");
    // Control power cycled: pending restart flag must clear
    sys_rst_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    chk(restart_pending_o, 1'b0);
    chk(busy_o, 1'b0);
    xfer(1'b0, SUB_SAVE_ALL, 32'h0);
    chk(ans, {1'b0, SAVE_ALL_RESET});
    $display("second power-on done");
    complete_run();
  end
endmodule : testbench
